//--- src/irq_pkg.sv
package irq_pkg;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int SRC_COUNT = 20;   // Number of sources
  localparam int IE_SRC_BITS = 7;  // Sources held in the low enable reg
  localparam int IDX_W = 5;        // Source index width
  localparam int ADDR_W = 8;       // APB address width used
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_IE = 8'h00;    // interrupt_enable_reg
  localparam logic [7:0] OFF_EIE = 8'h04;   // extended_enable_reg1
  localparam logic [7:0] OFF_IP = 8'h08;    // priority_sel_reg
  localparam logic [7:0] OFF_EIP = 8'h0c;   // Extended priority
  localparam logic [7:0] OFF_TIMER_CTRL_REG = 8'h10;  // timer_ctrl_reg
  localparam logic [7:0] OFF_PEND = 8'h14;  // All pending flags
  localparam logic [7:0] OFF_STAT = 8'h18;  // Service state
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int IE_GLOBAL_BIT = 7;  // global_irq_enable
  localparam int TC_IT0 = 0;         // ext0_trigger_select
  localparam int TC_IE0 = 1;         // ext0_pending_flag
  localparam int TC_IT1 = 2;         // ext1_trigger_select
  localparam int TC_IE1 = 3;         // ext1_pending_flag
  localparam int TC_TF0 = 5;         // timer0_overflow_flag
  localparam int TC_TF1 = 7;         // timer1_overflow_flag
  // Source order numbers
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  // ------------------------------------------------------------
  // Vectors and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'h0000;  // Reset vector
  localparam logic [15:0] VEC_BASE = 16'h0003;   // Order 0 vector
  localparam logic [15:0] VEC_STEP = 16'h0008;   // Vector spacing
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Service nesting state
  typedef enum logic [1:0] {
    SV_NONE = 2'b00,
    SV_LOW = 2'b01,
    SV_HIGH = 2'b10,
    SV_BOTH = 2'b11
  } svc_type;
endpackage : irq_pkg

//--- src/pick_if.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Request vector to lowest-order winner
// ------------------------------------------------------------
interface pick_if #(parameter int N = 20);
  import irq_pkg::*;
  logic [N-1:0] req;        // Candidate sources
  logic found;              // Any candidate
  logic [IDX_W-1:0] idx;    // Lowest candidate index
  modport finder(input req, output found, output idx);
  modport user(output req, input found, input idx);
endinterface : pick_if

//--- src/lowest_pick.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Lowest index finder
// ------------------------------------------------------------
module lowest_pick (
  // Request in, winner out
  pick_if.finder p
);
  import irq_pkg::*;
  // Scan from the top so the lowest set bit is kept last
  always_comb begin
    p.found = 1'b0;
    p.idx = '0;
    for (int i = $bits(p.req) - 1; i >= 0; i--) begin
      if (p.req[i]) begin
        p.found = 1'b1;
        p.idx = IDX_W'(i);
      end
    end
  end
endmodule : lowest_pick

//--- src/sync2.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Two-stage synchroniser
// ------------------------------------------------------------
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Async in, synced out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;  // First stage, read only by q
  // Only the second stage is visible to logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : sync2

//--- src/irq_ctrl.sv
//
// Operation
// RL1 - Twenty sources, each with two priority levels
// RL2 - Source event sets pending flag regardless enable
// RL3 - Enabled pending flag vectors after current instruction
// RL4 - Return instruction resumes interrupted program flow
// RL5 - Disabled source flag never produces request
// RL6 - Individual enables need global enable bit seven
// RL7 - Global enable low blocks every source
// RL8 - Single-cycle follower may still take request
// RL9 - Software follows enable clear with two-byte opcode
// RL10 - Some flags hardware cleared, others software cleared
// RL11 - Flag still set after return re-enters later
// RL12 - Software writing one acts as real event
// RL13 - Timer control bits select mode, hold flags
// RL14 - Edge-mode external flag cleared on vectoring
// RL15 - Level-mode external flag follows pin
// RL16 - Level source holds pin until recognised
// RL17 - Fixed vectors from 0x0003 stepping by eight
// RL18 - Enable and priority bits by source order
// RL19 - High preempts low; lowest order wins ties
// RL20 - Any of several source flags raises request
//
`timescale 1ns/10ps
module irq_ctrl #(
  parameter int NSRC = irq_pkg::SRC_COUNT
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [irq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral side
  input wire logic [NSRC-1:0] src_event,
  input wire logic [NSRC-1:0] periph_flags,
  input wire logic ext_irq_in_0_n,
  input wire logic ext_irq_in_1_n,
  // CPU sequencer side
  input wire logic instr_done,
  input wire logic next_single_cycle,
  input wire logic return_from_isr_instr_done,
  output logic vec_req,
  output logic [15:0] vec_addr
);
  import irq_pkg::*;
  localparam int EW = NSRC - IE_SRC_BITS;  // Extended enable width

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  // RL1 source count
  if (NSRC < IE_SRC_BITS + 1 || NSRC > SRC_COUNT) begin : g_bad
    $error("NSRC must lie between 8 and 20");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] ie_r, ie_nxt;             // Low enables plus global
  logic [EW-1:0] eie_r, eie_nxt;        // Extended enables
  logic [IE_SRC_BITS-1:0] ip_r, ip_nxt; // Low priority bits
  logic [EW-1:0] eip_r, eip_nxt;        // Extended priority bits
  logic [1:0] it_r, it_nxt;             // Trigger selects
  logic [NSRC-1:0] pend_r, pend_nxt;    // Pending flags
  logic [1:0] eprev_r, eprev_nxt;       // Previous pin active states
  logic grace_r, grace_nxt;             // Late global enable
  logic hold_r, hold_nxt;               // One instruction after return
  svc_type svc_r, svc_nxt;              // Nesting depth
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic vec_req_r, vec_req_nxt;
  logic [15:0] vec_addr_r, vec_addr_nxt;

  // ------------------------------------------------------------
  // Pins and pickers
  // ------------------------------------------------------------
  logic [1:0] pin_s;          // Synced active-low pins
  logic [1:0] act;            // Pin active
  logic [NSRC-1:0] ev;        // Hardware set events
  logic [NSRC-1:0] en_all;    // Per-source enables
  logic [NSRC-1:0] pri_all;   // Per-source priority
  logic [NSRC-1:0] cand;      // Requesting sources
  logic [NSRC-1:0] clr;       // Hardware clears on vectoring
  logic eff_ea;               // Global enable seen by arbiter
  logic take, take_hi;        // Vector this cycle
  logic [IDX_W-1:0] win;      // Winning source
  logic acc, wr_acc;          // APB access phases

  pick_if #(.N(NSRC)) hi_p ();
  pick_if #(.N(NSRC)) lo_p ();

  sync2 #(.W(2), .RST_VAL(2'b11)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({ext_irq_in_1_n, ext_irq_in_0_n}),
    .q(pin_s)
  );
  lowest_pick u_hi (.p(hi_p));
  lowest_pick u_lo (.p(lo_p));

  // ------------------------------------------------------------
  // Request generation
  // ------------------------------------------------------------
  always_comb begin
    act = ~pin_s;
    ev = src_event;
    // RL13 edge mode only latches a falling pin
    ev[SRC_EXT0] = it_r[0] & act[0] & ~eprev_r[0];
    ev[SRC_EXT1] = it_r[1] & act[1] & ~eprev_r[1];
    // RL18 enable and priority by order
    en_all = {eie_r, ie_r[IE_SRC_BITS-1:0]};
    pri_all = {eip_r, ip_r};
    // RL8 late clear still counts one instruction
    eff_ea = ie_r[IE_GLOBAL_BIT] | grace_r;
    // RL20 peripheral flag groups OR in
    // RL5 RL6 RL7 enable gating
    cand = (pend_r | periph_flags) & en_all & {NSRC{eff_ea}};
    // RL19 split by level
    hi_p.req = cand & pri_all;
    lo_p.req = cand & ~pri_all;
  end

  // ------------------------------------------------------------
  // Arbitration and vectoring
  // ------------------------------------------------------------
  always_comb begin
    // RL3 RL11 only at a boundary, not right after return
    take_hi = hi_p.found & (svc_r == SV_NONE || svc_r == SV_LOW);
    take = instr_done & ~hold_r & ~return_from_isr_instr_done &
           (take_hi | (lo_p.found & svc_r == SV_NONE));
    win = take_hi ? hi_p.idx : lo_p.idx;
    vec_req_nxt = take;
    vec_addr_nxt = vec_addr_r;
    if (take) begin
      // RL17 fixed vector per order
      vec_addr_nxt = 16'(VEC_BASE + VEC_STEP * 16'(win));
    end
    // RL10 RL14 timers and edge externals clear on vectoring
    clr = '0;
    if (take) begin
      clr[SRC_EXT0] = it_r[0] && win == IDX_W'(SRC_EXT0);
      clr[SRC_TMR0] = win == IDX_W'(SRC_TMR0);
      clr[SRC_EXT1] = it_r[1] && win == IDX_W'(SRC_EXT1);
      clr[SRC_TMR1] = win == IDX_W'(SRC_TMR1);
    end
    svc_nxt = svc_r;
    unique case (svc_r)
      // RL19 high nests over low only
      SV_NONE: begin
        if (take) svc_nxt = take_hi ? SV_HIGH : SV_LOW;
      end
      SV_LOW: begin
        if (take) svc_nxt = SV_BOTH;
        else if (return_from_isr_instr_done) svc_nxt = SV_NONE;
      end
      // RL4 return pops the active level
      SV_HIGH: begin
        if (return_from_isr_instr_done) svc_nxt = SV_NONE;
      end
      SV_BOTH: begin
        if (return_from_isr_instr_done) svc_nxt = SV_LOW;
      end
    endcase
    // RL11 one instruction runs after a return
    if (return_from_isr_instr_done) hold_nxt = 1'b1;
    else if (instr_done) hold_nxt = 1'b0;
    else hold_nxt = hold_r;
  end

  // ------------------------------------------------------------
  // APB decode and register writes
  // ------------------------------------------------------------
  always_comb begin
    // Two-cycle access; write lands on the ready edge
    acc = psel & penable & ~pready_r;
    wr_acc = psel & penable & pwrite & pready_r;
    pready_nxt = acc;
    pslverr_nxt = 1'b0;
    prdata_nxt = RST_WORD;
    ie_nxt = ie_r;
    eie_nxt = eie_r;
    ip_nxt = ip_r;
    eip_nxt = eip_r;
    it_nxt = it_r;
    pend_nxt = pend_r;
    eprev_nxt = act;
    if (acc) begin
      unique case (paddr)
        OFF_IE: prdata_nxt = 32'(ie_r);
        OFF_EIE: prdata_nxt = 32'(eie_r);
        OFF_IP: prdata_nxt = 32'(ip_r);
        OFF_EIP: prdata_nxt = 32'(eip_r);
        OFF_TIMER_CTRL_REG: begin
          prdata_nxt[TC_IT0] = it_r[0];
          prdata_nxt[TC_IE0] = pend_r[SRC_EXT0];
          prdata_nxt[TC_IT1] = it_r[1];
          prdata_nxt[TC_IE1] = pend_r[SRC_EXT1];
          prdata_nxt[TC_TF0] = pend_r[SRC_TMR0];
          prdata_nxt[TC_TF1] = pend_r[SRC_TMR1];
        end
        OFF_PEND: prdata_nxt = 32'(pend_r);
        OFF_STAT: prdata_nxt = {29'h0, grace_r, svc_r};
        // Unmapped address answers with an error
        default: pslverr_nxt = 1'b1;
      endcase
    end
    if (wr_acc) begin
      unique case (paddr)
        OFF_IE: ie_nxt = pwdata[7:0];
        OFF_EIE: eie_nxt = pwdata[EW-1:0];
        OFF_IP: ip_nxt = pwdata[IE_SRC_BITS-1:0];
        OFF_EIP: eip_nxt = pwdata[EW-1:0];
        // RL13 trigger selects and flag views
        OFF_TIMER_CTRL_REG: begin
          it_nxt = {pwdata[TC_IT1], pwdata[TC_IT0]};
          pend_nxt[SRC_EXT0] = pwdata[TC_IE0];
          pend_nxt[SRC_EXT1] = pwdata[TC_IE1];
          pend_nxt[SRC_TMR0] = pwdata[TC_TF0];
          pend_nxt[SRC_TMR1] = pwdata[TC_TF1];
        end
        // RL12 a written one stands like an event
        OFF_PEND: pend_nxt = pwdata[NSRC-1:0];
        default: pend_nxt = pend_r;
      endcase
    end
    // RL2 events set flags; set wins over any clear
    pend_nxt = (pend_nxt & ~clr) | ev;
    // RL15 level mode mirrors the pin, no latching
    if (!it_r[0]) pend_nxt[SRC_EXT0] = act[0];
    if (!it_r[1]) pend_nxt[SRC_EXT1] = act[1];
    // RL8 late clear grace if a single-cycle op follows
    if (wr_acc && paddr == OFF_IE && !pwdata[IE_GLOBAL_BIT] &&
        ie_r[IE_GLOBAL_BIT] && next_single_cycle) grace_nxt = 1'b1;
    else if (instr_done) grace_nxt = 1'b0;
    else grace_nxt = grace_r;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_r <= '0;
      eie_r <= '0;
      ip_r <= '0;
      eip_r <= '0;
      it_r <= '0;
      pend_r <= '0;
      eprev_r <= '0;
      grace_r <= 1'b0;
      hold_r <= 1'b0;
      svc_r <= SV_NONE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= RST_WORD;
      vec_req_r <= 1'b0;
      vec_addr_r <= VEC_RESET;
    end else begin
      ie_r <= ie_nxt;
      eie_r <= eie_nxt;
      ip_r <= ip_nxt;
      eip_r <= eip_nxt;
      it_r <= it_nxt;
      pend_r <= pend_nxt;
      eprev_r <= eprev_nxt;
      grace_r <= grace_nxt;
      hold_r <= hold_nxt;
      svc_r <= svc_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      vec_req_r <= vec_req_nxt;
      vec_addr_r <= vec_addr_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign vec_req = vec_req_r;
  assign vec_addr = vec_addr_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Prompt pacing: the first boundary lands two edges after a return
  sequence s_ret_then_boundary;
    return_from_isr_instr_done ##2 instr_done;
  endsequence

  a_vec_at_boundary: assert property ( // RL3
    vec_req |-> $past(instr_done) && !$past(hold_r))
    else $error("vector outside an instruction boundary");
  a_global_gate: assert property ( // RL7
    vec_req |-> $past(eff_ea) && $past(|cand))
    else $error("vector while globally disabled");
  a_disabled_quiet: assert property ( // RL5
    instr_done && (((pend_r | periph_flags) & en_all) == '0)
    |=> !vec_req)
    else $error("vector for a disabled source");
  a_vec_layout: assert property ( // RL17
    vec_req |-> vec_addr[2:0] == VEC_BASE[2:0] &&
    vec_addr < 16'(VEC_BASE + VEC_STEP * 16'(NSRC)))
    else $error("vector address off the table");
  a_return_from_isr_instr_gap: assert property ( // RL11
    s_ret_then_boundary |=> !vec_req)
    else $error("re-entry without one instruction");
  a_edge_clear: assert property ( // RL14
    take && win == IDX_W'(SRC_EXT0) && it_r[0] && !ev[SRC_EXT0]
    |=> !pend_r[SRC_EXT0])
    else $error("edge flag not cleared on vectoring");
  a_level_track: assert property ( // RL15
    !it_r[0] |=> pend_r[SRC_EXT0] == $past(act[0]))
    else $error("level flag does not follow pin");
  a_event_sets: assert property ( // RL2
    1'b1 |=> (pend_r & $past(ev)) == $past(ev))
    else $error("event lost on pending flag");
  a_hi_preempt: assert property ( // RL19
    instr_done && !hold_r && !return_from_isr_instr_done && hi_p.found &&
    svc_r == SV_LOW |=> vec_req ##1 svc_r == SV_BOTH)
    else $error("high request failed to preempt");
  a_sw_set: assert property ( // RL12
    wr_acc && paddr == OFF_PEND && pwdata[NSRC-1] |=> pend_r[NSRC-1])
    else $error("software set of a flag ignored");
endmodule : irq_ctrl

//--- sim/cpu_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Core sequencer stand-in
// ------------------------------------------------------------
module cpu_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench controls
  input wire logic slow,
  input wire logic ret_req,
  input wire logic single,
  // Sequencer outputs
  output logic instr_done,
  output logic next_single_cycle,
  output logic return_from_isr_instr_done
);
  logic [2:0] gap_r; // Cycles left to next boundary
  // multi-byte follower
  // Software keeps a long opcode after a global clear unless asked
  assign next_single_cycle = single;
  // Boundary pacing, prompt or slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 3'h0;
      instr_done <= 1'b0;
      return_from_isr_instr_done <= 1'b0;
    end else begin
      instr_done <= 1'b0;
      return_from_isr_instr_done <= 1'b0;
      if (gap_r != 3'h0) begin
        gap_r <= gap_r - 3'h1;
      end else begin
        // Gap of at least one idle cycle lets the bench drop ret_req
        gap_r <= slow ? 3'h4 : 3'h1;
        if (ret_req) begin
          return_from_isr_instr_done <= 1'b1;
        end else begin
          instr_done <= 1'b1;
        end
      end
    end
  end
endmodule : cpu_model

//--- sim/cpu_interrupt_handler_tb_top.sv
`timescale 1ns/10ps
module cpu_interrupt_handler_tb_top;
  import irq_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [SRC_COUNT-1:0] src_event = '0;
  logic [SRC_COUNT-1:0] periph_flags = '0;
  logic ext_irq_in_0_n = 1'b1; // Pins idle high
  logic ext_irq_in_1_n = 1'b1;
  logic instr_done;
  logic next_single_cycle;
  logic return_from_isr_instr_done;
  logic vec_req;
  logic [15:0] vec_addr;
  logic slow = 1'b0; // Sequencer pace
  logic ret_req = 1'b0; // Ask sequencer to return
  logic single = 1'b0; // Follower is single cycle
  int num_errors = 0;
  int cmp_count = 0;
  int nvec = 0; // Vectors seen
  int nv = 0; // Vectors expected
  logic [33:0] rq[$]; // Bus notes: check, error, data
  logic [15:0] vq[$]; // Expected vectors, oldest first
  logic [33:0] e;
  logic [31:0] r;
  always #50 pclk = ~pclk;
  irq_ctrl irq_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_event(src_event), .periph_flags(periph_flags),
    .ext_irq_in_0_n(ext_irq_in_0_n), .ext_irq_in_1_n(ext_irq_in_1_n),
    .instr_done(instr_done), .next_single_cycle(next_single_cycle),
    .return_from_isr_instr_done(return_from_isr_instr_done), .vec_req(vec_req), .vec_addr(vec_addr));
  cpu_model cpu_model_i (.pclk(pclk), .presetn(presetn), .slow(slow),
    .ret_req(ret_req), .single(single), .instr_done(instr_done),
    .next_single_cycle(next_single_cycle), .return_from_isr_instr_done(return_from_isr_instr_done));
  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // Monitor: bus answers and vectors against oldest notes
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = rq.pop_front();
      check("pslverr", 32'(pslverr), 32'(e[32]));
      if (e[33]) check("prdata", prdata, e[31:0]);
    end
    if (vec_req === 1'b1) begin
      if (vq.size() == 0) check("vec_extra", 32'h1, 32'h0);
      else check("vec_addr", 32'(vec_addr), 32'(vq.pop_front()));
      nvec <= nvec + 1;
    end
  end
  // ------------------------------------------------------------
  // Bus and sequencer tasks
  // ------------------------------------------------------------
  // Master holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic chk,
                     input logic err);
    int i;
    i = 0;
    rq.push_back({chk, err, d});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wr ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && i < 50) begin
      @(posedge pclk);
      i++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50) begin
      num_errors++;
      end_sim();
    end
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, d, 1'b1, 1'b0);
  endtask : rd
  task automatic vx(input int k);
    vq.push_back(VEC_BASE + VEC_STEP * 16'(k));
    nv++;
  endtask : vx
  task automatic wait_vec;
    int i;
    i = 0;
    while (nvec < nv && i < 300) begin
      @(posedge pclk);
      i++;
    end
    if (nvec < nv) begin
      num_errors++;
      end_sim();
    end
  endtask : wait_vec
  task automatic do_return_from_isr_instr;
    int i;
    i = 0;
    ret_req <= 1'b1;
    @(posedge pclk);
    while (return_from_isr_instr_done !== 1'b1 && i < 50) begin
      @(posedge pclk);
      i++;
    end
    ret_req <= 1'b0;
    // Let one edge pass so a following call never re-raises at once
    @(posedge pclk);
    if (i >= 50) begin
      num_errors++;
      end_sim();
    end
  endtask : do_return_from_isr_instr
  // Enable one source with the global bit
  task automatic en(input int k);
    wr(OFF_EIE, k < 7 ? 32'h0 : (32'h1 << (k - 7)));
    wr(OFF_IE, k < 7 ? (32'h80 | (32'h1 << k)) : 32'h80);
  endtask : en
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h27a95e21));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 7; a++) begin
      rd(8'(4 * a), 32'h0);
    end
    apb(1'b0, 8'h1c, 32'h0, 1'b1, 1'b1);
    wr(OFF_IE, 32'h7f);
    rd(OFF_IE, 32'h7f);
    wr(OFF_EIE, 32'hffff_ffff);
    rd(OFF_EIE, 32'h1fff);
    r = $urandom() & 32'hf_fffa;
    src_event <= r[SRC_COUNT-1:0];
    @(posedge pclk);
    src_event <= '0;
    rd(OFF_PEND, r);
    repeat (20) @(posedge pclk);
    wr(OFF_EIE, 32'h0);
    wr(OFF_IE, 32'h80);
    repeat (20) @(posedge pclk);
    wr(OFF_PEND, 32'h0);
    for (int k = 1; k < SRC_COUNT; k++) begin
      if (k == SRC_EXT1) continue;
      slow <= 1'($urandom() >> 5);
      en(k);
      vx(k);
      if (k < 4) begin
        src_event <= SRC_COUNT'(1) << k;
        @(posedge pclk);
        src_event <= '0;
      end else begin
        wr(OFF_PEND, 32'h1 << k);
      end
      wait_vec();
      rd(OFF_PEND, k < 4 ? 32'h0 : (32'h1 << k));
      wr(OFF_PEND, 32'h0);
      rd(OFF_STAT, 32'h1);
      do_return_from_isr_instr();
    end
    en(5);
    vx(5);
    wr(OFF_PEND, 32'h20);
    wait_vec();
    vx(5);
    do_return_from_isr_instr();
    wait_vec();
    wr(OFF_PEND, 32'h0);
    do_return_from_isr_instr();
    en(9);
    vx(9);
    periph_flags[9] <= 1'b1;
    wait_vec();
    periph_flags <= '0;
    do_return_from_isr_instr();
    wr(OFF_EIE, 32'h2);
    wr(OFF_EIP, 32'h2);
    wr(OFF_IE, 32'hd0);
    vx(4);
    wr(OFF_PEND, 32'h50);
    wait_vec();
    vx(8);
    wr(OFF_PEND, 32'h150);
    wait_vec();
    rd(OFF_STAT, 32'h3);
    wr(OFF_PEND, 32'h40);
    vx(6);
    do_return_from_isr_instr();
    do_return_from_isr_instr();
    wait_vec();
    wr(OFF_PEND, 32'h0);
    do_return_from_isr_instr();
    wr(OFF_TIMER_CTRL_REG, 32'h5);
    wr(OFF_IE, 32'h81);
    vx(0);
    ext_irq_in_0_n <= 1'b0;
    repeat (3) @(posedge pclk);
    ext_irq_in_0_n <= 1'b1;
    wait_vec();
    rd(OFF_TIMER_CTRL_REG, 32'h5);
    do_return_from_isr_instr();
    wr(OFF_TIMER_CTRL_REG, 32'h1);
    wr(OFF_IE, 32'h84);
    vx(2);
    ext_irq_in_1_n <= 1'b0;
    wait_vec();
    rd(OFF_TIMER_CTRL_REG, 32'h9);
    ext_irq_in_1_n <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(OFF_TIMER_CTRL_REG, 32'h1);
    do_return_from_isr_instr();
    // grace only with a single-cycle follower
    wr(OFF_IE, 32'h80);
    wr(OFF_PEND, 32'h20);
    single <= 1'b1;
    vx(5);
    wr(OFF_IE, 32'h20);
    wait_vec();
    rd(OFF_IE, 32'h20);
    rd(OFF_STAT, 32'h1);
    wr(OFF_PEND, 32'h0);
    do_return_from_isr_instr();
    // Multi-cycle follower: the same clear must block the request
    single <= 1'b0;
    wr(OFF_IE, 32'h80);
    wr(OFF_PEND, 32'h20);
    wr(OFF_IE, 32'h20);
    repeat (20) @(posedge pclk);
    wr(OFF_PEND, 32'h0);
    repeat (20) @(posedge pclk);
    check("vec_left", 32'(vq.size()), 32'h0);
    end_sim();
  end
endmodule : cpu_interrupt_handler_tb_top
